// ==== dtm_pkg.sv ====
// constants shared by the transfer mode logic: register map, mode fields, encodings, states
// assumes a 32-bit apb slave port with byte addresses and a simple 16-bit memory command port
package dtm_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_MODE    = 8'h00;
  localparam logic [7:0] OFF_COUNT_A = 8'h04;
  localparam logic [7:0] OFF_COUNT_B = 8'h08;
  localparam logic [7:0] OFF_SOURCE  = 8'h0c;
  localparam logic [7:0] OFF_DEST    = 8'h10;
  localparam logic [7:0] OFF_CTRL    = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;

  // transfer_mode_a field positions
  localparam int SIZE_BIT   = 0;
  localparam int SIDE_BIT   = 1;
  localparam int OPMODE_LSB = 2;
  localparam int DEST_LSB   = 4;
  localparam int SRC_LSB    = 6;

  // control and status bit positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // operating mode encodings
  localparam logic [1:0] OP_NORMAL = 2'b00;
  localparam logic [1:0] OP_REPEAT = 2'b01;
  localparam logic [1:0] OP_BLOCK  = 2'b10;

  // pointer update encodings, 00 and 01 both fixed
  localparam logic [1:0] UPD_INC = 2'b10;
  localparam logic [1:0] UPD_DEC = 2'b11;

  // reset values
  localparam logic [7:0]  MODE_RST  = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } dtm_state_t;

endpackage

// ==== dtm_transfer_mode_logic.sv ====
// transfer controller mode and addressing engine with its apb register file
// assumes apb master per protocol and a memory port that pulses memDone per finished command
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns

// How it works
// - size bit picks byte or word, step
// - side clear: destination is repeat/block area
// - side set: source is repeat/block area
// - mode field picks normal, repeat or block
// - destination fixed or incremented by size
// - destination decremented by one or two
// - source fixed or incremented by size
// - source decremented by one or two
// - destination pointer addresses every write
module dtm_transfer_mode_logic #(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              trigRequest,
  output logic                   busy,
  output logic                   xferDone,
  output logic                   memCmdValid,
  output logic                   memCmdWrite,
  output logic                   memCmdWord,
  output logic      [ADDR_W-1:0] memCmdAddr,
  output logic      [15:0]       memCmdWdata,
  input  wire logic              memDone,
  input  wire logic [15:0]       memRdata
);

  generate
    if (ADDR_W < 2 || ADDR_W > 32) begin : g_bad_width
      $error("ADDR_W must lie between 2 and 32");
    end
  endgenerate

  dtm_pkg::dtm_state_t state;
  dtm_pkg::dtm_state_t next_state;

  logic [7:0]        transferModeA;
  logic [15:0]       transferCountA;
  logic [15:0]       blockCountB;
  logic [ADDR_W-1:0] sourcePointer;
  logic [ADDR_W-1:0] destPointer;
  logic [ADDR_W-1:0] areaBase;
  logic [7:0]        blockLeft;
  logic              enable;
  logic              done;
  logic              areaArm;

  logic [7:0]        next_transferModeA;
  logic [15:0]       next_transferCountA;
  logic [15:0]       next_blockCountB;
  logic [ADDR_W-1:0] next_sourcePointer;
  logic [ADDR_W-1:0] next_destPointer;
  logic [ADDR_W-1:0] next_areaBase;
  logic [7:0]        next_blockLeft;
  logic              next_enable;
  logic              next_done;
  logic              next_areaArm;
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic              next_busy;
  logic              next_xferDone;
  logic              next_memCmdValid;
  logic              next_memCmdWrite;
  logic              next_memCmdWord;
  logic [ADDR_W-1:0] next_memCmdAddr;
  logic [15:0]       next_memCmdWdata;

  // decoded mode fields
  logic              sizeSelect;
  logic              repeatSideSelect;
  logic [1:0]        opMode;
  logic [1:0]        destUpdate;
  logic [1:0]        sourceUpdate;

  assign sizeSelect       = transferModeA[dtm_pkg::SIZE_BIT];
  assign repeatSideSelect = transferModeA[dtm_pkg::SIDE_BIT];
  assign opMode           = transferModeA[dtm_pkg::OPMODE_LSB +: 2];
  assign destUpdate       = transferModeA[dtm_pkg::DEST_LSB +: 2];
  assign sourceUpdate     = transferModeA[dtm_pkg::SRC_LSB +: 2];

  function automatic logic isMapped(input logic [7:0] addr);
    unique case (addr)
      dtm_pkg::OFF_MODE,
      dtm_pkg::OFF_COUNT_A,
      dtm_pkg::OFF_COUNT_B,
      dtm_pkg::OFF_SOURCE,
      dtm_pkg::OFF_DEST,
      dtm_pkg::OFF_CTRL,
      dtm_pkg::OFF_STATUS: isMapped = 1'b1;
      default:             isMapped = 1'b0;
    endcase
  endfunction

  // one pointer update after each transfer
  function automatic logic [ADDR_W-1:0] stepPtr(input logic [ADDR_W-1:0] ptr,
                                                input logic [1:0]        upd,
                                                input logic              word);
    logic [ADDR_W-1:0] stride;
    stride = word ? ADDR_W'(2) : ADDR_W'(1);
    unique case (upd)
      dtm_pkg::UPD_INC: stepPtr = ptr + stride;
      dtm_pkg::UPD_DEC: stepPtr = ptr - stride;
      default:          stepPtr = ptr;
    endcase
  endfunction

  logic              setupPhase;
  logic              accessWrite;
  logic              engineIdle;
  logic [ADDR_W-1:0] srcStep;
  logic [ADDR_W-1:0] dstStep;
  logic              unitFinish;
  logic              seqEnd;
  logic              areaRestore;

  assign setupPhase  = psel & ~penable;
  assign accessWrite = psel & penable & pready & pwrite & ~pslverr;
  assign engineIdle  = (state == dtm_pkg::ST_IDLE);
  assign srcStep     = stepPtr(sourcePointer, sourceUpdate, sizeSelect);
  assign dstStep     = stepPtr(destPointer, destUpdate, sizeSelect);

  always_comb begin
    next_state          = state;
    next_transferModeA  = transferModeA;
    next_transferCountA = transferCountA;
    next_blockCountB    = blockCountB;
    next_sourcePointer  = sourcePointer;
    next_destPointer    = destPointer;
    next_areaBase       = areaBase;
    next_blockLeft      = blockLeft;
    next_enable         = enable;
    next_done           = done;
    next_areaArm        = areaArm;
    next_memCmdValid    = memCmdValid;
    next_memCmdWrite    = memCmdWrite;
    next_memCmdWord     = memCmdWord;
    next_memCmdAddr     = memCmdAddr;
    next_memCmdWdata    = memCmdWdata;
    next_xferDone       = 1'b0;
    unitFinish          = 1'b0;
    seqEnd              = 1'b0;
    areaRestore         = 1'b0;

    // apb: no wait state, answer prepared in the setup cycle
    next_pready  = setupPhase;
    next_pslverr = setupPhase & ~isMapped(paddr);
    next_prdata  = 32'h0;
    if (setupPhase && !pwrite) begin
      unique case (paddr)
        dtm_pkg::OFF_MODE:    next_prdata = {24'h0, transferModeA};
        dtm_pkg::OFF_COUNT_A: next_prdata = {16'h0, transferCountA};
        dtm_pkg::OFF_COUNT_B: next_prdata = {16'h0, blockCountB};
        dtm_pkg::OFF_SOURCE:  next_prdata = 32'(sourcePointer);
        dtm_pkg::OFF_DEST:    next_prdata = 32'(destPointer);
        dtm_pkg::OFF_CTRL:    next_prdata = 32'(enable);
        dtm_pkg::OFF_STATUS:  next_prdata = 32'({done, ~engineIdle});
        default:              next_prdata = 32'h0;
      endcase
    end

    // setup registers are frozen while a unit is in flight
    if (accessWrite) begin
      unique case (paddr)
        dtm_pkg::OFF_MODE:    if (engineIdle) next_transferModeA = pwdata[7:0];
        dtm_pkg::OFF_COUNT_A: if (engineIdle) next_transferCountA = pwdata[15:0];
        dtm_pkg::OFF_COUNT_B: if (engineIdle) next_blockCountB = pwdata[15:0];
        dtm_pkg::OFF_SOURCE:  if (engineIdle) next_sourcePointer = pwdata[ADDR_W-1:0];
        dtm_pkg::OFF_DEST:    if (engineIdle) next_destPointer = pwdata[ADDR_W-1:0];
        dtm_pkg::OFF_CTRL: begin
          next_enable = pwdata[dtm_pkg::CTRL_EN_BIT];
          if (pwdata[dtm_pkg::CTRL_EN_BIT] && !enable) begin
            next_areaArm = 1'b1;
          end
        end
        dtm_pkg::OFF_STATUS: begin
          if (pwdata[dtm_pkg::STAT_DONE_BIT]) begin
            next_done = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // engine; placed after the bus so hardware sets win
    unique case (state)
      dtm_pkg::ST_IDLE: begin
        if (enable && trigRequest) begin
          next_state       = dtm_pkg::ST_READ;
          next_memCmdValid = 1'b1;
          next_memCmdWrite = 1'b0;
          next_memCmdWord  = sizeSelect;
          next_memCmdAddr  = sourcePointer;
          next_blockLeft   = transferCountA[15:8];
          if (opMode == dtm_pkg::OP_BLOCK || areaArm) begin
            next_areaArm  = 1'b0;
            next_areaBase = repeatSideSelect ? sourcePointer : destPointer;
          end
        end
      end
      dtm_pkg::ST_READ: begin
        if (memDone) begin
          next_state       = dtm_pkg::ST_WRITE;
          next_memCmdWrite = 1'b1;
          next_memCmdAddr  = destPointer;
          next_memCmdWdata = sizeSelect ? memRdata : {8'h00, memRdata[7:0]};
        end
      end
      dtm_pkg::ST_WRITE: begin
        if (memDone) begin
          next_sourcePointer = srcStep;
          next_destPointer   = dstStep;
          unique case (opMode)
            dtm_pkg::OP_REPEAT: begin
              unitFinish = 1'b1;
              if (transferCountA[7:0] == 8'h01) begin
                next_transferCountA[7:0] = transferCountA[15:8];
                areaRestore              = 1'b1;
              end else begin
                next_transferCountA[7:0] = transferCountA[7:0] - 8'h01;
              end
            end
            dtm_pkg::OP_BLOCK: begin
              next_blockLeft = blockLeft - 8'h01;
              if (blockLeft == 8'h01) begin
                unitFinish       = 1'b1;
                areaRestore      = 1'b1;
                next_blockCountB = blockCountB - 16'h0001;
                seqEnd           = (blockCountB == 16'h0001);
              end
            end
            default: begin
              unitFinish          = 1'b1;
              next_transferCountA = transferCountA - 16'h0001;
              seqEnd              = (transferCountA == 16'h0001);
            end
          endcase
          if (areaRestore) begin
            if (repeatSideSelect) begin
              next_sourcePointer = areaBase;
            end else begin
              next_destPointer = areaBase;
            end
          end
          if (unitFinish) begin
            next_state       = dtm_pkg::ST_IDLE;
            next_memCmdValid = 1'b0;
            next_memCmdWrite = 1'b0;
            next_xferDone    = 1'b1;
            if (seqEnd) begin
              next_enable = 1'b0;
              next_done   = 1'b1;
            end
          end else begin
            next_state       = dtm_pkg::ST_READ;
            next_memCmdWrite = 1'b0;
            next_memCmdAddr  = next_sourcePointer;
          end
        end
      end
    endcase

    next_busy = (next_state != dtm_pkg::ST_IDLE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state          <= dtm_pkg::ST_IDLE;
      transferModeA  <= dtm_pkg::MODE_RST;
      transferCountA <= dtm_pkg::COUNT_RST;
      blockCountB    <= dtm_pkg::COUNT_RST;
      sourcePointer  <= '0;
      destPointer    <= '0;
      areaBase       <= '0;
      blockLeft      <= 8'h00;
      enable         <= 1'b0;
      done           <= 1'b0;
      areaArm        <= 1'b0;
      prdata         <= 32'h0;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      busy           <= 1'b0;
      xferDone       <= 1'b0;
      memCmdValid    <= 1'b0;
      memCmdWrite    <= 1'b0;
      memCmdWord     <= 1'b0;
      memCmdAddr     <= '0;
      memCmdWdata    <= 16'h0000;
    end else begin
      state          <= next_state;
      transferModeA  <= next_transferModeA;
      transferCountA <= next_transferCountA;
      blockCountB    <= next_blockCountB;
      sourcePointer  <= next_sourcePointer;
      destPointer    <= next_destPointer;
      areaBase       <= next_areaBase;
      blockLeft      <= next_blockLeft;
      enable         <= next_enable;
      done           <= next_done;
      areaArm        <= next_areaArm;
      prdata         <= next_prdata;
      pready         <= next_pready;
      pslverr        <= next_pslverr;
      busy           <= next_busy;
      xferDone       <= next_xferDone;
      memCmdValid    <= next_memCmdValid;
      memCmdWrite    <= next_memCmdWrite;
      memCmdWord     <= next_memCmdWord;
      memCmdAddr     <= next_memCmdAddr;
      memCmdWdata    <= next_memCmdWdata;
    end
  end

endmodule

// ==== dtm_assertions.sv ====
// port checker for the transfer mode engine
// assumes one clock, the zero-wait apb answer and a held memory command
`timescale 1ns/1ns
module dtm_checker #(
  parameter int ADDR_W = 16
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              busy,
  input wire logic              xferDone,
  input wire logic              memCmdValid,
  input wire logic              memCmdWrite,
  input wire logic              memCmdWord,
  input wire logic [ADDR_W-1:0] memCmdAddr,
  input wire logic [15:0]       memCmdWdata,
  input wire logic              memDone,
  input wire logic [15:0]       memRdata
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_wait; psel && !penable |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready not one cycle after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error outside access or with data");
  property p_start; $rose(busy) |-> memCmdValid && !memCmdWrite; endproperty
  a_start: assert property (p_start) else $error("service not opened by a read");
  property p_hold;
    memCmdValid && !memDone |=> memCmdValid && $stable(memCmdAddr) && $stable(memCmdWrite);
  endproperty
  a_hold: assert property (p_hold) else $error("command changed before done");
  property p_pair;
    memCmdValid && !memCmdWrite && memDone |=> memCmdWrite && memCmdWord == $past(memCmdWord);
  endproperty
  a_pair: assert property (p_pair) else $error("read not followed by write");
  property p_word;
    memCmdValid && !memCmdWrite && memDone && memCmdWord |=> memCmdWdata == $past(memRdata);
  endproperty
  a_word: assert property (p_word) else $error("word data not carried");
  property p_byte;
    memCmdValid && !memCmdWrite && memDone && !memCmdWord
      |=> memCmdWdata == ($past(memRdata) & 16'h00ff);
  endproperty
  a_byte: assert property (p_byte) else $error("byte data not carried");
  property p_end; xferDone |-> !busy && !memCmdValid ##1 !xferDone; endproperty
  a_end: assert property (p_end) else $error("done pulse while active");
  c_done: cover property (xferDone);
  c_err: cover property (pslverr);
  c_word: cover property (memCmdValid && memCmdWrite && memCmdWord && memDone);
endmodule

bind dtm_transfer_mode_logic dtm_checker #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rstn(rstn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busy(busy), .xferDone(xferDone), .memCmdValid(memCmdValid), .memCmdWrite(memCmdWrite),
  .memCmdWord(memCmdWord), .memCmdAddr(memCmdAddr), .memCmdWdata(memCmdWdata),
  .memDone(memDone), .memRdata(memRdata));

// ==== dtm_mem_model.sv ====
// memory side model answering engine commands with address-derived data
// assumes each command is held until memDone
`timescale 1ns/1ns
module dtm_mem_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        memCmdValid,
  input  wire logic [15:0] memCmdAddr,
  output logic             memDone,
  output logic [15:0]      memRdata
);
  int waitLeft;
  // random data while not answering, random wait of 0 to 3 cycles
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      memDone <= 1'b0;
      memRdata <= 16'h0;
      waitLeft <= 0;
    end else if (memCmdValid && !memDone && waitLeft == 0) begin
      memDone <= 1'b1;
      memRdata <= memCmdAddr ^ 16'ha55a;
    end else begin
      memDone <= 1'b0;
      memRdata <= 16'($urandom);
      if (memDone) waitLeft <= $urandom_range(3, 0);
      else if (waitLeft > 0) waitLeft <= waitLeft - 1;
    end
  end
endmodule

// ==== dtm_testbench.sv ====
// self-checking bench of the transfer mode engine with a memory model
// assumes the zero-wait apb slave and the model's data pattern
`timescale 1ns/1ns
module testbench;
  logic        clk, rstn, psel, penable, pwrite, trigRequest;
  logic        pready, pslverr, busy, xferDone, memDone;
  logic        memCmdValid, memCmdWrite, memCmdWord;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] memCmdAddr, memCmdWdata, memRdata;
  logic [32:0] rq[$], wq[$];
  int          n_mismatch, total_checks;

  dtm_transfer_mode_logic dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigRequest(trigRequest), .busy(busy), .xferDone(xferDone),
    .memCmdValid(memCmdValid), .memCmdWrite(memCmdWrite), .memCmdWord(memCmdWord),
    .memCmdAddr(memCmdAddr), .memCmdWdata(memCmdWdata), .memDone(memDone),
    .memRdata(memRdata));
  dtm_mem_model mem (.clk(clk), .rstn(rstn), .memCmdValid(memCmdValid),
    .memCmdAddr(memCmdAddr), .memDone(memDone), .memRdata(memRdata));

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [32:0] got, input logic [32:0] exp);
    chk(got, exp);
  endtask

  task automatic chk_mem(input logic [32:0] got, input logic [32:0] exp);
    chk(got, exp);
  endtask

  task automatic test_done;
    if (rq.size() + wq.size() != 0) n_mismatch++;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] v);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(a, 1'b1, v);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(a, 1'b0, $urandom);
  endtask

  function automatic logic [15:0] upd(input logic [15:0] p, input logic [1:0] u, input int st);
    return u == 2'b10 ? p + 16'(st) : u == 2'b11 ? p - 16'(st) : p;
  endfunction

  task automatic run(input logic [7:0] m, input logic [15:0] ca, cb, input int nt,
                     input logic en);
    logic [15:0] s, d, bs, bd;
    int          rc;
    s = 16'($urandom);
    d = 16'($urandom);
    rc = ca[7:0];
    bs = s;
    bd = d;
    wr(8'h18, 32'h2);
    wr(8'h00, {24'h0, m});
    wr(8'h04, {16'h0, ca});
    wr(8'h08, {16'h0, cb});
    wr(8'h0c, {16'h0, s});
    wr(8'h10, {16'h0, d});
    wr(8'h14, 32'h1);
    rd(8'h00, {25'h0, m});
    repeat (nt) begin
      if (m[3:2] == 2'b10) begin
        bs = s;
        bd = d;
      end
      repeat (m[3:2] == 2'b10 ? ca[15:8] : 1) begin
        wq.push_back({m[0], d, m[0] ? s ^ 16'ha55a : {8'h00, s[7:0] ^ 8'h5a}});
        s = upd(s, m[7:6], m[0] ? 2 : 1);
        d = upd(d, m[5:4], m[0] ? 2 : 1);
        rc--;
        if (m[3:2] == 2'b01 && rc == 0) begin
          rc = ca[15:8];
          if (m[1]) s = bs; else d = bd;
        end
      end
      if (m[3:2] == 2'b10) begin
        if (m[1]) s = bs; else d = bd;
      end
      @(posedge clk);
      trigRequest <= 1'b1;
      @(posedge clk);
      trigRequest <= 1'b0;
      for (int k = 0; k < 300 && xferDone !== 1'b1; k++) @(posedge clk);
      @(posedge clk);
    end
    rd(8'h0c, {17'h0, s});
    rd(8'h10, {17'h0, d});
    rd(8'h14, {32'h0, en});
    rd(8'h18, en ? 33'h0 : 33'h2);
    if (en) wr(8'h14, 32'h0);
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) chk_reg({pslverr, prdata}, rq.pop_front());
    if (memCmdValid && memCmdWrite && memDone)
      chk_mem({memCmdWord, memCmdAddr, memCmdWdata}, wq.pop_front());
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #300000;
    n_mismatch++;
    test_done();
  end

  initial begin
    void'($urandom(32'hae8adc6a));
    {rstn, psel, penable, pwrite, trigRequest} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00, 33'h0);
    rd(8'h04, 33'h0);
    rd(8'h1c, 33'h100000000);
    // second half uses mode code 11, which must behave as normal
    for (int i = 0; i < 64; i++)
      run({i[4:1], i[5], i[5], i[2], i[0]}, 16'h2, 16'h1, 2, 1'b0);
    for (int j = 0; j < 2; j++)
      run({6'b101010, j[0], 1'b1}, 16'h0300, 16'h2, 2, 1'b0);
    for (int j = 0; j < 2; j++)
      run({6'b111001, j[0], 1'b0}, 16'h0202, 16'h1, 3, 1'b1);
    test_done();
  end
endmodule
